/* pcsl_pkg.sv */
package pcsl_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned NUM_ERR = 4;

    localparam logic [ADDR_W-1:0] OFS_DEV_ERR_STATUS = 8'hc8;
    localparam logic [ADDR_W-1:0] OFS_LINK_CAPS = 8'hcc;

    // Device control/status dword
    localparam int unsigned BIT_RPT_EN_LSB = 0;
    localparam int unsigned BIT_ERR_LSB = 16;
    localparam int unsigned BIT_AUX_PWR = 20;
    localparam int unsigned BIT_TXN_PEND = 21;
    localparam int unsigned BYTE_RPT_EN = 0;
    localparam int unsigned BYTE_ERR = 2;
    localparam logic AUX_PWR_RST = 1'b1;
    localparam logic TXN_PEND_VAL = 1'b0;

    // Error index order within the flag and enable groups
    localparam int unsigned ERR_CORR = 0;
    localparam int unsigned ERR_NONFATAL = 1;
    localparam int unsigned ERR_FATAL = 2;
    localparam int unsigned ERR_UNSUP = 3;

    // Link capabilities field layout
    localparam int unsigned LC_SPEED_LSB = 0;
    localparam int unsigned LC_SPEED_W = 4;
    localparam int unsigned LC_WIDTH_LSB = 4;
    localparam int unsigned LC_WIDTH_W = 6;
    localparam int unsigned LC_ASPM_LSB = 10;
    localparam int unsigned LC_ASPM_W = 2;
    localparam int unsigned LC_L0S_LSB = 12;
    localparam int unsigned LC_L0S_W = 3;
    localparam int unsigned LC_L1_LSB = 15;
    localparam int unsigned LC_L1_W = 3;
    localparam int unsigned LC_DLLA = 20;
    localparam int unsigned LC_BWN = 21;
    localparam int unsigned LC_PORT_LSB = 24;
    localparam int unsigned LC_PORT_W = 8;

    localparam logic [LC_SPEED_W-1:0] SPEED_RST = 4'h2;
    localparam logic [LC_WIDTH_W-1:0] WIDTH_RST = 6'h01;
    localparam logic [LC_ASPM_W-1:0] ASPM_RST = 2'h0;
    localparam logic [LC_L0S_W-1:0] L0S_RST = 3'h3;
    localparam logic [LC_L1_W-1:0] L1_RST = 3'h0;
endpackage

/* pcsl_sticky_flag.sv */
`timescale 1ns/10ps
module pcsl_sticky_flag (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic setEvt,
    input wire logic clearReq,
    output logic flag
);
    logic flag_r;
    logic flag_nxt;

    // Set wins over a same-cycle clear so no event is lost
    always_comb begin
        flag_nxt = setEvt | (flag_r & ~clearReq);
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    assign flag = flag_r;
endmodule

/* pcsl_port_regs.sv */
`timescale 1ns/10ps
// How it works
// - Correctable error event sets bit 16; sticky until software writes one; resets zero.
// - Non-fatal error event sets bit 17; write one clears, zero ignored; resets zero.
// - Fatal error event sets bit 18; cleared only by writing one; resets zero.
// - Unsupported request event sets bit 19; write one clears; resets zero.
// - All four flags log regardless of the reporting enables.
// - Bit 20 read-only shows auxiliary power detected; resets to one.
// - Transactions pending bit 21 always reads zero.
// - Link caps bits 3:0 give maximum speed; reset code 0010b for 5 Gb/s.
// - Bits 9:4 give maximum width, read-only; reset encodes one lane.
// - Bits 11:10 give ASPM support level; reset value 00b.
// - Bits 14:12 give L0s exit latency; reset 011b, 256ns up to 512ns.
// - Bits 17:15 give L1 exit latency; reset 000b, 16us up to 32us.
// - Data-link-active capability bit 20 zero upstream; one on hot-plug downstream ports.
// - Bandwidth notification bit 21 zero upstream, one on downstream ports.
// - Bits 31:24 hold port number; resets to the port index.
// - Speed, ASPM, latencies, port number loadable by side port; config writes ignored.
// - Four reporting enables in low half, gate reporting only, reset zero.
module pcsl_port_regs
    import pcsl_pkg::*;
#(
    parameter logic [LC_PORT_W-1:0] PORT_INDEX = 8'h00,
    parameter bit IS_UPSTREAM = 1'b1,
    parameter bit HOT_PLUG_CAPABLE = 1'b0
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic cfgWrite,
    input wire logic cfgRead,
    input wire logic [ADDR_W-1:0] cfgAddr,
    input wire logic [DATA_W-1:0] cfgWrData,
    input wire logic [DATA_W/8-1:0] cfgByteEn,
    output logic [DATA_W-1:0] cfgRdData,
    output logic cfgRdValid,
    input wire logic sideLoad,
    input wire logic [DATA_W-1:0] sideLoadData,
    input wire logic corrErrEvt,
    input wire logic nonFatalErrEvt,
    input wire logic fatalErrEvt,
    input wire logic unsupReqEvt,
    input wire logic auxPowerPresent,
    output logic [NUM_ERR-1:0] errReportEn,
    output logic [NUM_ERR-1:0] errReport,
    output logic [NUM_ERR-1:0] errFlags
);
    localparam bit DLLA_VAL = !IS_UPSTREAM && HOT_PLUG_CAPABLE;
    localparam bit BWN_VAL = !IS_UPSTREAM;

    logic [NUM_ERR-1:0] errEvt;
    logic [NUM_ERR-1:0] errClear;
    logic [NUM_ERR-1:0] flagQ;
    logic wrStatus;
    logic rdStatus;
    logic rdCaps;

    logic [NUM_ERR-1:0] rptEn_r;
    logic [NUM_ERR-1:0] rptEn_nxt;
    logic [NUM_ERR-1:0] report_r;
    logic [NUM_ERR-1:0] report_nxt;
    logic auxPwr_r;
    logic auxPwr_nxt;
    logic [LC_SPEED_W-1:0] speed_r;
    logic [LC_SPEED_W-1:0] speed_nxt;
    logic [LC_ASPM_W-1:0] aspm_r;
    logic [LC_ASPM_W-1:0] aspm_nxt;
    logic [LC_L0S_W-1:0] l0s_r;
    logic [LC_L0S_W-1:0] l0s_nxt;
    logic [LC_L1_W-1:0] l1_r;
    logic [LC_L1_W-1:0] l1_nxt;
    logic [LC_PORT_W-1:0] portNum_r;
    logic [LC_PORT_W-1:0] portNum_nxt;
    logic [DATA_W-1:0] rdData_r;
    logic [DATA_W-1:0] rdData_nxt;
    logic rdValid_r;
    logic rdValid_nxt;
    logic [DATA_W-1:0] statusWord;
    logic [DATA_W-1:0] capsWord;

    assign errEvt[ERR_CORR] = corrErrEvt;
    assign errEvt[ERR_NONFATAL] = nonFatalErrEvt;
    assign errEvt[ERR_FATAL] = fatalErrEvt;
    assign errEvt[ERR_UNSUP] = unsupReqEvt;

    assign wrStatus = cfgWrite && (cfgAddr == OFS_DEV_ERR_STATUS);
    assign rdStatus = cfgAddr == OFS_DEV_ERR_STATUS;
    assign rdCaps = cfgAddr == OFS_LINK_CAPS;

    // One sticky cell per error kind; enables never reach the set input
    genvar gi;
    generate
        for (gi = 0; gi < NUM_ERR; gi++) begin : g_err
            assign errClear[gi] = wrStatus && cfgByteEn[BYTE_ERR] && cfgWrData[BIT_ERR_LSB + gi];
            pcsl_sticky_flag u_flag (
                .clock(clock),
                .rst_n(rst_n),
                .setEvt(errEvt[gi]),
                .clearReq(errClear[gi]),
                .flag(flagQ[gi])
            );
        end
    endgenerate

    always_comb begin
        rptEn_nxt = rptEn_r;
        if (wrStatus && cfgByteEn[BYTE_RPT_EN]) begin
            rptEn_nxt = cfgWrData[BIT_RPT_EN_LSB +: NUM_ERR];
        end
        // Reporting is the only thing the enables gate; they also read back in the status word and drive errReportEn
        report_nxt = errEvt & rptEn_r;
        auxPwr_nxt = auxPowerPresent;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rptEn_r <= '0;
            report_r <= '0;
            auxPwr_r <= AUX_PWR_RST;
        end else begin
            rptEn_r <= rptEn_nxt;
            report_r <= report_nxt;
            auxPwr_r <= auxPwr_nxt;
        end
    end

    // Capability defaults change only through the side port, never config writes
    always_comb begin
        speed_nxt = speed_r;
        aspm_nxt = aspm_r;
        l0s_nxt = l0s_r;
        l1_nxt = l1_r;
        portNum_nxt = portNum_r;
        if (sideLoad) begin
            speed_nxt = sideLoadData[LC_SPEED_LSB +: LC_SPEED_W];
            aspm_nxt = sideLoadData[LC_ASPM_LSB +: LC_ASPM_W];
            l0s_nxt = sideLoadData[LC_L0S_LSB +: LC_L0S_W];
            l1_nxt = sideLoadData[LC_L1_LSB +: LC_L1_W];
            portNum_nxt = sideLoadData[LC_PORT_LSB +: LC_PORT_W];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            speed_r <= SPEED_RST;
            aspm_r <= ASPM_RST;
            l0s_r <= L0S_RST;
            l1_r <= L1_RST;
            portNum_r <= PORT_INDEX;
        end else begin
            speed_r <= speed_nxt;
            aspm_r <= aspm_nxt;
            l0s_r <= l0s_nxt;
            l1_r <= l1_nxt;
            portNum_r <= portNum_nxt;
        end
    end

    always_comb begin
        statusWord = '0;
        statusWord[BIT_RPT_EN_LSB +: NUM_ERR] = rptEn_r;
        statusWord[BIT_ERR_LSB +: NUM_ERR] = flagQ;
        statusWord[BIT_AUX_PWR] = auxPwr_r;
        statusWord[BIT_TXN_PEND] = TXN_PEND_VAL;
        capsWord = '0;
        capsWord[LC_SPEED_LSB +: LC_SPEED_W] = speed_r;
        capsWord[LC_WIDTH_LSB +: LC_WIDTH_W] = WIDTH_RST;
        capsWord[LC_ASPM_LSB +: LC_ASPM_W] = aspm_r;
        capsWord[LC_L0S_LSB +: LC_L0S_W] = l0s_r;
        capsWord[LC_L1_LSB +: LC_L1_W] = l1_r;
        capsWord[LC_DLLA] = DLLA_VAL;
        capsWord[LC_BWN] = BWN_VAL;
        capsWord[LC_PORT_LSB +: LC_PORT_W] = portNum_r;
    end

    // Read data captured a cycle later; unmapped offsets return zero
    always_comb begin
        rdValid_nxt = cfgRead;
        rdData_nxt = rdData_r;
        if (cfgRead) begin
            if (rdStatus) begin
                rdData_nxt = statusWord;
            end else if (rdCaps) begin
                rdData_nxt = capsWord;
            end else begin
                rdData_nxt = '0;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdData_r <= '0;
            rdValid_r <= 1'b0;
        end else begin
            rdData_r <= rdData_nxt;
            rdValid_r <= rdValid_nxt;
        end
    end

    assign cfgRdData = rdData_r;
    assign cfgRdValid = rdValid_r;
    assign errReportEn = rptEn_r;
    assign errReport = report_r;
    assign errFlags = flagQ;

    sequence s_corr_evt;
        corrErrEvt;
    endsequence

    sequence s_corr_held;
        errFlags[ERR_CORR] && !errClear[ERR_CORR];
    endsequence

    a_corr_flag_set: assert property (@(posedge clock) disable iff (!rst_n)
        s_corr_evt |=> errFlags[ERR_CORR])
        else $error("Correctable flag did not set");

    a_corr_flag_sticky: assert property (@(posedge clock) disable iff (!rst_n)
        s_corr_held |=> errFlags[ERR_CORR])
        else $error("Correctable flag dropped without clear");

    a_nonfatal_clear: assert property (@(posedge clock) disable iff (!rst_n)
        (errClear[ERR_NONFATAL] && !nonFatalErrEvt) |=> !errFlags[ERR_NONFATAL])
        else $error("Non-fatal flag not cleared by write one");

    a_fatal_only_w1c: assert property (@(posedge clock) disable iff (!rst_n)
        $fell(errFlags[ERR_FATAL]) |-> $past(errClear[ERR_FATAL]))
        else $error("Fatal flag cleared without write one");

    a_unsup_set_wins: assert property (@(posedge clock) disable iff (!rst_n)
        (unsupReqEvt && errClear[ERR_UNSUP]) |=> errFlags[ERR_UNSUP])
        else $error("Unsupported request event lost on clear");

    a_log_without_enable: assert property (@(posedge clock) disable iff (!rst_n)
        (fatalErrEvt && !errReportEn[ERR_FATAL]) |=> (errFlags[ERR_FATAL] && !errReport[ERR_FATAL]))
        else $error("Flag or report wrong with reporting disabled");

    a_status_read_data: assert property (@(posedge clock) disable iff (!rst_n)
        (cfgRead && rdStatus) |=> (cfgRdValid && cfgRdData[BIT_TXN_PEND] == 1'b0
            && cfgRdData[DATA_W-1:BIT_TXN_PEND+1] == '0 && cfgRdData[BIT_AUX_PWR] == $past(auxPwr_r)))
        else $error("Status read data wrong");

    a_caps_read_data: assert property (@(posedge clock) disable iff (!rst_n)
        (cfgRead && rdCaps) |=> (cfgRdData[LC_WIDTH_LSB +: LC_WIDTH_W] == WIDTH_RST
            && cfgRdData[LC_DLLA] == DLLA_VAL && cfgRdData[LC_BWN] == BWN_VAL
            && cfgRdData[LC_BWN+1 +: 2] == '0 && cfgRdData[LC_L1_LSB+LC_L1_W +: 2] == '0))
        else $error("Capability read data wrong");

    a_caps_no_cfgwrite: assert property (@(posedge clock) disable iff (!rst_n)
        !sideLoad |=> ($stable(speed_r) && $stable(aspm_r) && $stable(l0s_r) && $stable(l1_r) && $stable(portNum_r)))
        else $error("Capability changed without side load");

    a_enable_write: assert property (@(posedge clock) disable iff (!rst_n)
        (wrStatus && cfgByteEn[BYTE_RPT_EN]) |=> errReportEn == $past(cfgWrData[BIT_RPT_EN_LSB +: NUM_ERR]))
        else $error("Reporting enables not written");

    a_unmapped_zero: assert property (@(posedge clock) disable iff (!rst_n)
        (cfgRead && !rdStatus && !rdCaps) |=> (cfgRdValid && cfgRdData == '0))
        else $error("Unmapped read not zero");
endmodule

/* pcsl_tb.sv */
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin fails++; $display("Error %s expected %h seen %h", nm, ex, got); end end
module tb;
    import pcsl_pkg::*;
    // Downstream hot-plug port 3, so both capability bits read one
    localparam logic [DATA_W-1:0] CAPS_DEF = 32'h03303012;
    localparam logic [DATA_W-1:0] STAT_DEF = 32'h00100000;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic cfgWrite = 1'b0;
    logic cfgRead = 1'b0;
    logic [ADDR_W-1:0] cfgAddr = 8'h00;
    logic [DATA_W-1:0] cfgWrData = 32'h0;
    logic [DATA_W/8-1:0] cfgByteEn = 4'h0;
    logic [DATA_W-1:0] cfgRdData;
    logic cfgRdValid;
    logic sideLoad = 1'b0;
    logic [DATA_W-1:0] sideLoadData = 32'h0;
    logic [3:0] evt = 4'h0;
    logic auxPowerPresent = 1'b1;
    logic [NUM_ERR-1:0] errReportEn;
    logic [NUM_ERR-1:0] errReport;
    logic [NUM_ERR-1:0] errFlags;
    int fails = 0;
    int compares = 0;

    always #12.5 clock = ~clock;

    pcsl_port_regs #(.PORT_INDEX(8'h03), .IS_UPSTREAM(1'b0), .HOT_PLUG_CAPABLE(1'b1)) pcsl_port_regs_i (
        .clock(clock), .rst_n(rst_n), .cfgWrite(cfgWrite), .cfgRead(cfgRead), .cfgAddr(cfgAddr),
        .cfgWrData(cfgWrData), .cfgByteEn(cfgByteEn), .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid),
        .sideLoad(sideLoad), .sideLoadData(sideLoadData), .corrErrEvt(evt[0]), .nonFatalErrEvt(evt[1]),
        .fatalErrEvt(evt[2]), .unsupReqEvt(evt[3]), .auxPowerPresent(auxPowerPresent),
        .errReportEn(errReportEn), .errReport(errReport), .errFlags(errFlags));

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] ex, input string nm);
        @(posedge clock);
        cfgRead <= 1'b1;
        cfgAddr <= a;
        @(posedge clock);
        cfgRead <= 1'b0;
        #1;
        `CHK("cfgRdValid", 1'b1, cfgRdValid)
        `CHK(nm, ex, cfgRdData)
        // Answer must stand for exactly one cycle
        @(posedge clock);
        #1;
        `CHK("cfgRdValid drop", 1'b0, cfgRdValid)
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [3:0] be);
        @(posedge clock);
        cfgWrite <= 1'b1;
        cfgAddr <= a;
        cfgWrData <= d;
        cfgByteEn <= be;
        @(posedge clock);
        cfgWrite <= 1'b0;
    endtask

    // Event held for exactly one edge; flags and report land one cycle later
    task automatic pulse(input logic [3:0] e, input logic [3:0] exFlags, input logic [3:0] exRpt);
        @(posedge clock);
        evt <= e;
        @(posedge clock);
        evt <= 4'h0;
        #1;
        `CHK("errFlags", exFlags, errFlags)
        `CHK("errReport", exRpt, errReport)
    endtask

    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        logic [3:0] acc;
        acc = 4'h0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        #1;
        `CHK("errReportEn", 4'h0, errReportEn)
        rd(OFS_DEV_ERR_STATUS, STAT_DEF, "status reset");
        rd(OFS_LINK_CAPS, CAPS_DEF, "caps reset");
        wr(OFS_LINK_CAPS, 32'hffffffff, 4'hf);
        rd(OFS_LINK_CAPS, CAPS_DEF, "caps after write");
        rd(8'h40, 32'h0, "unmapped");
        // Enables are all off here, so any report pulse is a leak
        for (int i = 0; i < NUM_ERR; i++) begin
            acc = acc | (4'h1 << i);
            pulse(4'h1 << i, acc, 4'h0);
        end
        rd(OFS_DEV_ERR_STATUS, STAT_DEF | 32'h000f0000, "flags set");
        wr(OFS_DEV_ERR_STATUS, 32'h0, 4'h4);
        rd(OFS_DEV_ERR_STATUS, STAT_DEF | 32'h000f0000, "write zero");
        for (int i = 0; i < NUM_ERR; i++) begin
            wr(OFS_DEV_ERR_STATUS, 32'h1 << (BIT_ERR_LSB + i), 4'h4);
            acc = acc & ~(4'h1 << i);
            #1;
            `CHK("errFlags clear", acc, errFlags)
        end
        // Event, clear and read in one cycle: set wins, read sees old state
        @(posedge clock);
        evt <= 4'h8;
        cfgWrite <= 1'b1;
        cfgRead <= 1'b1;
        cfgAddr <= OFS_DEV_ERR_STATUS;
        cfgWrData <= 32'h00080000;
        cfgByteEn <= 4'h4;
        @(posedge clock);
        evt <= 4'h0;
        cfgWrite <= 1'b0;
        cfgRead <= 1'b0;
        #1;
        `CHK("set wins", 4'h8, errFlags)
        `CHK("read before write", STAT_DEF, cfgRdData)
        wr(OFS_DEV_ERR_STATUS, 32'h00080000, 4'h4);
        #1;
        `CHK("flag after clear", 4'h0, errFlags)
        wr(OFS_DEV_ERR_STATUS, 32'hffffffff, 4'h1);
        rd(OFS_DEV_ERR_STATUS, STAT_DEF | 32'h0000000f, "enables");
        `CHK("errReportEn", 4'hf, errReportEn)
        pulse(4'hf, 4'hf, 4'hf);
        @(posedge clock);
        #1;
        `CHK("errReport end", 4'h0, errReport)
        @(posedge clock);
        sideLoad <= 1'b1;
        sideLoadData <= 32'hffffffff;
        @(posedge clock);
        sideLoad <= 1'b0;
        rd(OFS_LINK_CAPS, 32'hff33fc1f, "loaded caps");
        wr(OFS_LINK_CAPS, 32'h0, 4'hf);
        rd(OFS_LINK_CAPS, 32'hff33fc1f, "loaded caps write");
        @(posedge clock);
        auxPowerPresent <= 1'b0;
        rd(OFS_DEV_ERR_STATUS, 32'h000f000f, "aux low");
        // Second reset in mid-run must drop loaded fields and flags
        @(posedge clock);
        rst_n <= 1'b0;
        auxPowerPresent <= 1'b1;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        rd(OFS_LINK_CAPS, CAPS_DEF, "caps rereset");
        rd(OFS_DEV_ERR_STATUS, STAT_DEF, "status rereset");
        wrap_up();
    end

    // Whole run is under a hundred cycles; allow over twenty times that
    initial begin
        #50000;
        fails++;
        wrap_up();
    end
endmodule
